// ---- synth_port_pkg.sv ----
// constants and carrier types of the synthesizer serial programming port
// assumes one system clock; all port pins arrive unsynchronised
package synth_port_pkg;

    localparam int WORD_W   = 24;          // bits in one serial word
    localparam int SEL_W    = 4;           // register select field, lowest bits of the word
    localparam int PWR_W    = 4;           // power control field width
    localparam int PWR_LSB  = 20;          // power control field position in the power register

    localparam logic [SEL_W-1:0] LOCK_SEL = 4'h0;  // lock trigger register
    localparam logic [SEL_W-1:0] PWR_SEL  = 4'h1;  // register holding the power control bits

    localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
    localparam logic [PWR_W-1:0]  PWR_RST  = 4'h0;

    // pins as seen from the device
    typedef struct packed {
        logic sclk;     // serial clock
        logic sdata;    // serial data
        logic strobe;   // load strobe
        logic ce;       // chip enable
    } pins_type;

    // status outputs of the port
    typedef struct packed {
        logic [PWR_W-1:0] section_en;     // sections powered
        logic             acq_restart;    // one-cycle pulse: restart lock acquisition
        logic             relock_pending; // powered up, lock trigger not yet reloaded
        logic             load_done;      // one-cycle pulse: a register was loaded
    } status_type;

endpackage

// ---- synth_reg_bank.sv ----
// destination register bank, one write port and one registered read port
// assumes write strobes are already in the mclk domain
`timescale 1ns/10ps
module synth_reg_bank #(
    parameter int WORD_W = synth_port_pkg::WORD_W,
    parameter int SEL_W  = synth_port_pkg::SEL_W
) (
    input  wire logic              mclk,     // system clock
    input  wire logic              rst,      // synchronous reset, active high
    input  wire logic              wr_en,    // write one word
    input  wire logic [SEL_W-1:0]  wr_addr,  // destination register
    input  wire logic [WORD_W-1:0] wr_data,  // word to store
    input  wire logic [SEL_W-1:0]  rd_addr,  // read address
    output logic      [WORD_W-1:0] rd_data   // read data, one cycle later
);
    import synth_port_pkg::*;

    localparam int DEPTH = 1 << SEL_W;

    typedef struct packed {
        logic [DEPTH-1:0][WORD_W-1:0] mem;
        logic [WORD_W-1:0]            rd;
    } bank_type;

    bank_type bank_q;
    bank_type bank_d;

    always_comb begin
        bank_d    = bank_q;
        bank_d.rd = bank_q.mem[rd_addr];
        if (wr_en) begin
            bank_d.mem[wr_addr] = wr_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            bank_q.mem <= {DEPTH{WORD_W'(WORD_RST)}};
            bank_q.rd  <= WORD_W'(WORD_RST);
        end else begin
            bank_q <= bank_d;
        end
    end

    assign rd_data = bank_q.rd;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_bank_hold_idle: assert property (!wr_en |=> bank_q.mem == $past(bank_q.mem))
        else $error("register bank changed without a load");
    a_bank_write_lands: assert property (wr_en |=> bank_q.mem[$past(wr_addr)] == $past(wr_data))
        else $error("loaded word not stored at selected register");

endmodule

// ---- synth_serial_program_port.sv ----
// three-wire serial programming port: shift register, load into selected register,
// chip-enable power gating and lock re-acquisition trigger
// assumes the serial pins are asynchronous to mclk and much slower (80 ns serial period)
`timescale 1ns/10ps

module synth_serial_program_port #(
    parameter int WORD_W = synth_port_pkg::WORD_W,
    parameter int SEL_W  = synth_port_pkg::SEL_W
) (
    input  wire logic                      mclk,     // system clock, 200 MHz
    input  wire logic                      rst,      // synchronous reset, active high
    input  wire synth_port_pkg::pins_type  pins,     // raw serial and enable pins
    input  wire logic [SEL_W-1:0]          rd_addr,  // register read address
    output logic      [WORD_W-1:0]         rd_data,  // register read data, registered
    output synth_port_pkg::status_type     status    // power and lock status, registered
);
    import synth_port_pkg::*;

    typedef struct packed {
        pins_type          s1;       // first synchroniser stage
        pins_type          s2;       // second synchroniser stage
        pins_type          prev;     // s2 one cycle earlier, for edges
        logic [WORD_W-1:0] shift;
        logic [PWR_W-1:0]  pwr;      // copy of the power control field
        status_type        stat;
    } state_type;

    state_type st_q;
    state_type st_d;

    localparam state_type ST_RST = '{
        s1:    '0,
        s2:    '0,
        prev:  '0,
        shift: WORD_W'(WORD_RST),
        pwr:   PWR_RST,
        stat:  '0
    };

    logic              sclk_rise;
    logic              strobe_rise;
    logic              ce_rise;
    logic [SEL_W-1:0]  sel;
    logic              lock_load;
    logic              pwr_load;

    assign sclk_rise   = st_q.s2.sclk & ~st_q.prev.sclk;
    assign strobe_rise = st_q.s2.strobe & ~st_q.prev.strobe;
    assign ce_rise     = st_q.s2.ce & ~st_q.prev.ce;
    assign sel         = st_q.shift[SEL_W-1:0];
    // loads are not gated by chip enable
    assign lock_load   = strobe_rise & (sel == LOCK_SEL);
    assign pwr_load    = strobe_rise & (sel == PWR_SEL);

    always_comb begin
        st_d      = st_q;
        st_d.s1   = pins;
        st_d.s2   = st_q.s1;
        st_d.prev = st_q.s2;

        // new bit enters at the bottom, so the first bit ends at the top
        if (sclk_rise) begin
            st_d.shift = {st_q.shift[WORD_W-2:0], st_q.s2.sdata};
        end

        if (pwr_load) begin
            st_d.pwr = st_q.shift[PWR_LSB +: PWR_W];
        end

        st_d.stat.section_en  = st_q.s2.ce ? st_q.pwr : PWR_RST;
        st_d.stat.load_done   = strobe_rise;
        st_d.stat.acq_restart = lock_load;

        // power-up sets, lock trigger load clears; a power-up in the same cycle wins
        if (ce_rise) begin
            st_d.stat.relock_pending = 1'h1;
        end else if (lock_load) begin
            st_d.stat.relock_pending = 1'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    synth_reg_bank #(
        .WORD_W (WORD_W),
        .SEL_W  (SEL_W)
    ) u_bank (
        .mclk    (mclk),
        .rst     (rst),
        .wr_en   (strobe_rise),
        .wr_addr (sel),
        .wr_data (st_q.shift),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    assign status = st_q.stat;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_shift_msb_first: assert property (sclk_rise |=> st_q.shift[WORD_W-1:1] == $past(st_q.shift[WORD_W-2:0])
                                        && st_q.shift[0] == $past(st_q.s2.sdata))
        else $error("shift register did not move toward the top");
    a_shift_on_edge: assert property (!sclk_rise |=> st_q.shift == $past(st_q.shift))
        else $error("shift register moved without a serial clock rise");
    a_sclk_edge_seen: assert property ($rose(st_q.s2.sclk) |-> sclk_rise)
        else $error("serial clock rise missed");
    a_select_power: assert property (strobe_rise && sel == PWR_SEL
                                     |=> st_q.pwr == $past(st_q.shift[PWR_LSB +: PWR_W]))
        else $error("power register load did not take the shifted field");
    a_power_hold: assert property (!pwr_load |=> st_q.pwr == $past(st_q.pwr))
        else $error("power bits changed without their load");
    a_power_gate: assert property (##1 st_q.stat.section_en == ($past(st_q.s2.ce) ? $past(st_q.pwr) : PWR_RST))
        else $error("section enables do not follow chip enable and power bits");
    a_load_while_down: assert property (strobe_rise && !st_q.s2.ce |=> st_q.stat.load_done)
        else $error("load refused while powered down");
    a_restart_cause: assert property (st_q.stat.acq_restart |-> $past(strobe_rise) && $past(sel) == LOCK_SEL)
        else $error("lock restart without lock trigger load");
    a_relock_wait: assert property (st_q.stat.relock_pending && !lock_load |=> st_q.stat.relock_pending)
        else $error("relock pending dropped without lock trigger load");

    // pin stages, checked only once a full cycle lies outside reset
    a_sync_first: assert property (
        !$past(rst) |-> st_q.s1 == $past(pins))
        else $error("first pin stage did not take the pins");

    a_sync_second: assert property (
        !$past(rst) |-> st_q.s2 == $past(st_q.s1))
        else $error("second pin stage did not take the first");

    a_edge_history: assert property (
        !$past(rst) |-> st_q.prev == $past(st_q.s2))
        else $error("edge history did not take the second stage");

    // load strobe pulses
    a_load_pulse: assert property (
        strobe_rise |=> st_q.stat.load_done)
        else $error("load strobe rise gave no load pulse");

    a_load_cause: assert property (
        st_q.stat.load_done |-> $past(strobe_rise))
        else $error("load pulse without a load strobe rise");

    a_load_single: assert property (
        st_q.stat.load_done |=> !st_q.stat.load_done)
        else $error("load pulse longer than one cycle");

    a_pulses_quiet: assert property (
        !strobe_rise |=> !st_q.stat.load_done && !st_q.stat.acq_restart)
        else $error("pulse raised without a load strobe rise");

    // path from shift register into the bank
    a_word_to_bank: assert property (
        strobe_rise ##1 (rd_addr == $past(sel)) |=> rd_data == $past(st_q.shift, 2))
        else $error("loaded word not read back from selected register");

    a_shift_keeps_load: assert property (
        strobe_rise && !sclk_rise |=> st_q.shift == $past(st_q.shift))
        else $error("shift register disturbed by a load");

    // lock re-acquisition
    a_restart_on_lock: assert property (
        lock_load |=> st_q.stat.acq_restart)
        else $error("lock trigger load gave no restart");

    a_restart_single: assert property (
        st_q.stat.acq_restart |=> !st_q.stat.acq_restart)
        else $error("restart pulse longer than one cycle");

    a_select_lock_only: assert property (
        strobe_rise && sel != LOCK_SEL |=> !st_q.stat.acq_restart)
        else $error("restart from a load of another register");

    a_relock_set: assert property (
        ce_rise |=> st_q.stat.relock_pending)
        else $error("power-up did not mark relock pending");

    a_relock_clear: assert property (
        lock_load && !ce_rise |=> !st_q.stat.relock_pending)
        else $error("lock trigger load did not clear relock pending");

    a_relock_cause: assert property (
        $rose(st_q.stat.relock_pending) |-> $past(ce_rise))
        else $error("relock pending raised without power-up");

    a_relock_idle: assert property (
        !st_q.stat.relock_pending && !ce_rise |=> !st_q.stat.relock_pending)
        else $error("relock pending raised while chip enable stayed");

    a_lock_while_down: assert property (
        lock_load && !st_q.s2.ce |=> st_q.stat.acq_restart)
        else $error("lock trigger load refused while powered down");

    // power sections
    a_power_down: assert property (
        !st_q.s2.ce |=> st_q.stat.section_en == PWR_RST)
        else $error("sections powered with chip enable low");

    a_power_up: assert property (
        st_q.s2.ce |=> st_q.stat.section_en == $past(st_q.pwr))
        else $error("sections do not follow power bits with chip enable high");

    a_power_other_sel: assert property (
        strobe_rise && sel != PWR_SEL |=> st_q.pwr == $past(st_q.pwr))
        else $error("power bits changed by a load of another register");

endmodule

// ---- host_model.sv ----
// host controller model: shifts words into the serial port and raises the load strobe
// assumes the bench clock mclk; the serial clock half period is 8 mclk cycles (80 ns period)
`timescale 1ns/10ps
module host_model (
    input  wire logic mclk,   // bench clock, used only for pacing
    output logic      sclk,   // serial clock, still outside frames
    output logic      sdata,  // serial data
    output logic      strobe  // load strobe
);
    initial begin
        sclk   = 1'b0;
        sdata  = 1'b0;
        strobe = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic send(input logic [synth_port_pkg::WORD_W-1:0] w);
        for (int i = synth_port_pkg::WORD_W - 1; i >= 0; i--) begin
            sdata = w[i];
            hold(8);
            sclk = 1'b1;
            hold(8);
            sclk = 1'b0;
        end
        // a released data line must not keep showing the last bit
        sdata = ~sdata;
        hold(4);
        strobe = 1'b1;
        hold(8);
        strobe = 1'b0;
        hold(8);
    endtask
endmodule

// ---- tb_top.sv ----
// self-checking bench of the serial programming port with a host model
// assumes the design package and a 200 MHz mclk
`timescale 1ns/10ps
module tb_top;
    import synth_port_pkg::*;
    logic              mclk, rst, ce, sclk, sdata, strobe, pend;
    logic [SEL_W-1:0]  rd_addr;
    logic [WORD_W-1:0] rd_data;
    logic [WORD_W-1:0] exp_reg [16];
    logic [31:0]       lfsr_q;
    pins_type          pins;
    status_type        status;
    int                bad_count, cmp_count, loads, acqs;
    assign pins = '{sclk: sclk, sdata: sdata, strobe: strobe, ce: ce};
    always #2.5 mclk = ~mclk;
    host_model HOST (.mclk(mclk), .sclk(sclk), .sdata(sdata), .strobe(strobe));
    synth_serial_program_port DUT (.mclk(mclk), .rst(rst), .pins(pins), .rd_addr(rd_addr),
                                   .rd_data(rd_data), .status(status));
    always @(posedge mclk) begin
        if (status.load_done === 1'b1) loads++;
        if (status.acq_restart === 1'b1) acqs++;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic stat_check;
        check(WORD_W'(status.section_en), ce ? WORD_W'(exp_reg[PWR_SEL][PWR_LSB +: PWR_W]) : WORD_W'(PWR_RST));
        check(WORD_W'(status.relock_pending), WORD_W'(pend));
    endtask
    task automatic set_ce(input logic v);
        if (v && !ce) pend = 1'b1;
        ce = v;
        HOST.hold(6);
        stat_check();
    endtask
    task automatic put(input logic [SEL_W-1:0] sel, input logic [19:0] body);
        loads = 0;
        acqs  = 0;
        rd_addr = sel;
        HOST.send({body, sel});
        exp_reg[sel] = {body, sel};
        if (sel == LOCK_SEL) pend = 1'b0;
        check(WORD_W'(loads), WORD_W'(1));
        check(WORD_W'(acqs), WORD_W'(sel == LOCK_SEL));
        for (int a = 0; a < 16; a++) begin
            rd_addr = SEL_W'(a);
            HOST.hold(2);
            check(rd_data, exp_reg[a]);
        end
        stat_check();
    endtask
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        ce = 1'b0;
        pend = 1'b0;
        rd_addr = '0;
        lfsr_q = 32'h8c8bdae1;
        for (int a = 0; a < 16; a++) exp_reg[a] = WORD_RST;
        HOST.hold(16);
        rst = 1'b0;
        HOST.hold(4);
        put(PWR_SEL, 20'hA5A5A);
        put(LOCK_SEL, 20'h0F0F0);
        set_ce(1'b1);
        put(PWR_SEL, 20'h5FFFF);
        put(LOCK_SEL, 20'h12345);
        for (int n = 0; n < 12; n++) begin
            lfsr_q = lfsr(lfsr_q);
            if (lfsr_q[31]) set_ce(lfsr_q[30]);
            put(lfsr_q[SEL_W-1:0], lfsr_q[27:8]);
        end
        final_report();
    end
    initial begin
        #200000;
        bad_count++;
        final_report();
    end
endmodule
